// File: common/lj_inc_pkg.sv
// package: constants and types for the long jump / register increment execution block
package lj_inc_pkg;

	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int DATA_W = 8;
	localparam int PC_W = 21;
	localparam int LIT_W = 20;
	localparam int BANK_W = 4;
	localparam int ADDR_W = 12;
	localparam int FLAG_W = 5;

	// ----------------------------------------
	// opcode prefixes
	// ----------------------------------------
	localparam logic [7:0] JUMP_FIRST_PREFIX = 8'hEF;
	localparam logic [3:0] JUMP_SECOND_PREFIX = 4'hF;
	localparam logic [5:0] INCR_PREFIX = 6'h0A;

	// ----------------------------------------
	// instruction word field positions
	// ----------------------------------------
	localparam int INCR_DEST_BIT = 9;
	localparam int INCR_BANK_BIT = 8;

	// ----------------------------------------
	// status flag positions
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;

	// ----------------------------------------
	// quarter phases (value of the phase counter)
	// ----------------------------------------
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q3 = 2'h2;
	localparam logic [1:0] PHASE_Q4 = 2'h3;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [DATA_W-1:0] WREG_RESET = 8'h00;
	localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h00;

	// ----------------------------------------
	// access bank mapping defaults
	// ----------------------------------------
	localparam logic [DATA_W-1:0] ACCESS_SPLIT_DEFAULT = 8'h80;
	localparam logic [BANK_W-1:0] ACCESS_LOW_BANK_DEFAULT = 4'h0;
	localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK_DEFAULT = 4'hF;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_JUMP_WORD2,
		ST_JUMP_NOP,
		ST_INCR
	} exec_state_type;

endpackage

// File: common/incr_if.sv
// interface: operand and result between the execution core and the incrementer
`timescale 1ns/1ns
interface incr_if;
	logic [7:0] operand;
	logic [7:0] result;
	logic [4:0] flags;

	modport core (output operand, input result, input flags);
	modport alu (input operand, output result, output flags);
endinterface

// File: hw/incr_alu.sv
// module: 8-bit add-one unit with status flag generation
`timescale 1ns/1ns
module incr_alu (
	// operand in, result and flags out
	incr_if.alu bus
);
	import lj_inc_pkg::*;

	logic [8:0] sum;

	always_comb begin
		sum = {1'b0, bus.operand} + 9'h001;
		bus.result = sum[7:0];
		bus.flags = FLAGS_RESET;
		bus.flags[FLAG_C] = sum[8];
		// nibble carry only happens when the low nibble was all ones
		bus.flags[FLAG_DC] = (bus.operand[3:0] == 4'hF);
		bus.flags[FLAG_Z] = (sum[7:0] == 8'h00);
		// adding one to a positive value overflows only at the sign boundary
		bus.flags[FLAG_OV] = (sum[7:0] == 8'h80);
		bus.flags[FLAG_N] = sum[7];
	end
endmodule // incr_alu

// File: hw/long_jump_and_increment_exec.sv
// module: execution of the two-word long jump and the register increment
//
// Contract
// - long jump is two words: prefix EF with low byte, prefix F with bits 19..8.
// - long jump loads the 20-bit literal into program counter bits 20..1.
// - long jump takes two cycles; PC written end of first; second cycle all no-ops.
// - increment reads the 8-bit register and adds one; jump leaves flags alone.
// - destination bit 0 writes working register, 1 writes back to the source register.
// - bank bit 0 addresses the access bank, ignoring the bank select register.
// - bank bit 1 addresses the bank chosen by the bank select register.
`timescale 1ns/1ns
module long_jump_and_increment_exec #(
	parameter logic [7:0] ACCESS_SPLIT = lj_inc_pkg::ACCESS_SPLIT_DEFAULT,
	parameter logic [3:0] ACCESS_LOW_BANK = lj_inc_pkg::ACCESS_LOW_BANK_DEFAULT,
	parameter logic [3:0] ACCESS_HIGH_BANK = lj_inc_pkg::ACCESS_HIGH_BANK_DEFAULT
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// program memory
	input wire logic [lj_inc_pkg::WORD_W-1:0] i_instr_word,
	input wire logic i_instr_valid,
	// bank select
	input wire logic [lj_inc_pkg::BANK_W-1:0] i_bank_select_register,
	// data register file
	output logic o_reg_rd_en,
	output logic [lj_inc_pkg::ADDR_W-1:0] o_reg_addr,
	input wire logic [lj_inc_pkg::DATA_W-1:0] i_reg_rd_data,
	output logic o_reg_wr_en,
	output logic [lj_inc_pkg::DATA_W-1:0] o_reg_wr_data,
	// working register, flags, program counter
	output logic [lj_inc_pkg::DATA_W-1:0] o_wreg,
	output logic [lj_inc_pkg::FLAG_W-1:0] o_status,
	output logic [lj_inc_pkg::PC_W-1:0] o_pc,
	output logic o_pc_load,
	// phase and activity
	output logic [1:0] o_phase,
	output logic o_busy
);
	import lj_inc_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [1:0] phase;
		exec_state_type state;
		logic [7:0] jump_low;
		logic dest_reg;
		logic [ADDR_W-1:0] addr;
		logic rd_en;
		logic wr_en;
		logic [DATA_W-1:0] wr_data;
		logic [DATA_W-1:0] wreg;
		logic [FLAG_W-1:0] status;
		logic [PC_W-1:0] pc;
		logic pc_load;
		logic busy;
	} exec_regs_type;

	localparam exec_regs_type REGS_RESET = '{
		phase: PHASE_Q1,
		state: ST_IDLE,
		jump_low: 8'h00,
		dest_reg: 1'b1,
		addr: 12'h000,
		rd_en: 1'b0,
		wr_en: 1'b0,
		wr_data: 8'h00,
		wreg: WREG_RESET,
		status: FLAGS_RESET,
		pc: PC_RESET,
		pc_load: 1'b0,
		busy: 1'b0
	};

	exec_regs_type r;
	exec_regs_type next_r;

	// ----------------------------------------
	// incrementer
	// ----------------------------------------
	incr_if alu_bus ();

	incr_alu u_incr_alu (
		.bus(alu_bus.alu)
	);

	// register file answers one clock after the read strobe, during Q3
	assign alu_bus.operand = i_reg_rd_data;

	// ----------------------------------------
	// instruction word fields
	// ----------------------------------------
	logic [7:0] op_byte;
	logic [3:0] op_nibble;
	logic [5:0] op_incr;
	logic [11:0] lit_high;
	logic [7:0] lit_low;
	logic dest_bit;
	logic bank_bit;

	// sliced once, so the decoders and the datapath always read the same bits
	always_comb begin
		op_byte = i_instr_word[15:8];
		op_nibble = i_instr_word[15:12];
		op_incr = i_instr_word[15:10];
		lit_high = i_instr_word[11:0];
		lit_low = i_instr_word[7:0];
		dest_bit = i_instr_word[INCR_DEST_BIT];
		bank_bit = i_instr_word[INCR_BANK_BIT];
	end

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	logic is_jump_first;
	logic is_jump_second;
	logic is_incr;
	logic [7:0] f_field;
	logic [BANK_W-1:0] access_bank;

	always_comb begin
		is_jump_first = (op_byte == JUMP_FIRST_PREFIX);
		is_jump_second = (op_nibble == JUMP_SECOND_PREFIX);
		is_incr = (op_incr == INCR_PREFIX);
		f_field = lit_low;
		// the access bank splits the 8-bit field at ACCESS_SPLIT, into its low and high halves by default
		if (f_field < ACCESS_SPLIT) begin
			access_bank = ACCESS_LOW_BANK;
		end else begin
			access_bank = ACCESS_HIGH_BANK;
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		next_r = r;
		// the phase counter is the divider: one instruction cycle is four clocks
		next_r.phase = r.phase + 2'h1;
		next_r.rd_en = 1'b0;
		next_r.wr_en = 1'b0;
		next_r.pc_load = 1'b0;
		case (r.state)
			ST_IDLE: begin
				if (r.phase == PHASE_Q1 && i_instr_valid) begin
					if (is_jump_first) begin
						next_r.jump_low = lit_low;
						next_r.state = ST_JUMP_WORD2;
					end else if (is_incr) begin
						next_r.dest_reg = dest_bit;
						if (bank_bit) begin
							next_r.addr = {i_bank_select_register, f_field};
						end else begin
							next_r.addr = {access_bank, f_field};
						end
						next_r.rd_en = 1'b1;
						next_r.state = ST_INCR;
					end
				end
			end
			ST_JUMP_WORD2: begin
				// second word is presented by program memory during Q4
				if (r.phase == PHASE_Q4) begin
					if (is_jump_second) begin
						next_r.pc = {lit_high, r.jump_low, 1'b0};
						next_r.pc_load = 1'b1;
					end
					next_r.state = ST_JUMP_NOP;
				end
			end
			ST_JUMP_NOP: begin
				// whole second cycle is a no-op; incoming words are ignored
				if (r.phase == PHASE_Q4) begin
					next_r.state = ST_IDLE;
				end
			end
			ST_INCR: begin
				if (r.phase == PHASE_Q3) begin
					next_r.status = alu_bus.flags;
					if (r.dest_reg) begin
						next_r.wr_en = 1'b1;
						next_r.wr_data = alu_bus.result;
					end else begin
						next_r.wreg = alu_bus.result;
					end
					next_r.state = ST_IDLE;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase
		// registered so the activity flag carries no decode glitch
		next_r.busy = (next_r.state != ST_IDLE);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			r <= REGS_RESET;
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign o_reg_rd_en = r.rd_en;
	assign o_reg_addr = r.addr;
	assign o_reg_wr_en = r.wr_en;
	assign o_reg_wr_data = r.wr_data;
	assign o_wreg = r.wreg;
	assign o_status = r.status;
	assign o_pc = r.pc;
	assign o_pc_load = r.pc_load;
	assign o_phase = r.phase;
	assign o_busy = r.busy;

endmodule // long_jump_and_increment_exec

// File: dv/long_jump_and_increment_exec_monitor.sv
// checker: timing and value relations at the ports of the execution block
`timescale 1ns/1ns
module lj_inc_monitor (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// program memory and bank select
	input wire logic [15:0] i_instr_word,
	input wire logic i_instr_valid,
	input wire logic [3:0] i_bank_select_register,
	// data register file
	input wire logic o_reg_rd_en,
	input wire logic [11:0] o_reg_addr,
	input wire logic [7:0] i_reg_rd_data,
	input wire logic o_reg_wr_en,
	input wire logic [7:0] o_reg_wr_data,
	// core state
	input wire logic [7:0] o_wreg,
	input wire logic [4:0] o_status,
	input wire logic [20:0] o_pc,
	input wire logic o_pc_load,
	input wire logic [1:0] o_phase,
	input wire logic o_busy
);
	import lj_inc_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	chk_rd_pulse: assert property (o_reg_rd_en |-> o_phase == PHASE_Q2 ##1 !o_reg_rd_en)
		else $error("register read strobe out of place");
	chk_wr_timing: assert property (o_reg_wr_en |-> o_phase == PHASE_Q4 && $past(o_reg_rd_en, 2))
		else $error("register write not in the fourth quarter of an increment");
	chk_wr_sum: assert property (o_reg_wr_en |-> o_reg_wr_data == 8'($past(i_reg_rd_data) + 1))
		else $error("written value is not read value plus one");
	chk_zero_carry: assert property (o_reg_wr_en |->
		o_status[FLAG_Z] == (o_reg_wr_data == 8'h00) && o_status[FLAG_C] == o_status[FLAG_Z])
		else $error("zero or carry flag wrong");
	chk_flags_src: assert property ($changed(o_status) |-> $past(o_reg_rd_en, 2))
		else $error("flags changed outside an increment");
	chk_wreg_src: assert property ($changed(o_wreg) |-> $past(o_reg_rd_en, 2) && !o_reg_wr_en)
		else $error("working register changed without an increment to it");
	chk_pc_lit: assert property (o_pc_load |->
		o_pc == {$past(i_instr_word[11:0]), $past(i_instr_word[7:0], 4), 1'b0})
		else $error("program counter not loaded from the two literal parts");
	chk_jump_len: assert property (o_pc_load |-> o_phase == PHASE_Q1 ##0 o_busy [*4] ##1 !o_busy)
		else $error("long jump does not last two cycles");
	chk_pc_src: assert property ($changed(o_pc) |-> o_pc_load)
		else $error("program counter changed without a jump");
	chk_addr_sel: assert property (o_reg_rd_en |->
		o_reg_addr == {($past(i_instr_word[INCR_BANK_BIT]) ? $past(i_bank_select_register)
		: ($past(i_instr_word[7:0]) < ACCESS_SPLIT_DEFAULT ? ACCESS_LOW_BANK_DEFAULT
		: ACCESS_HIGH_BANK_DEFAULT)), $past(i_instr_word[7:0])})
		else $error("register address does not follow the bank-access bit");
endmodule // lj_inc_monitor

// File: dv/reg_file_model.sv
// model: data register file answering reads one clock after the strobe
`timescale 1ns/1ns
module reg_file_model (
	// clock
	input wire logic i_core_clk,
	// register file side of the block
	input wire logic i_rd_en,
	input wire logic [11:0] i_addr,
	input wire logic i_wr_en,
	input wire logic [7:0] i_wr_data,
	output logic [7:0] o_rd_data = 8'h5A
);
	logic [7:0] mem [4096];
	// outside a read the data toggles, so a late sample never sees a stale match
	always @(posedge i_core_clk) begin
		o_rd_data <= i_rd_en ? mem[i_addr] : ~o_rd_data;
		if (i_wr_en) mem[i_addr] <= i_wr_data;
	end
endmodule // reg_file_model

// File: dv/long_jump_and_increment_exec_tb.sv
// testbench: issues jumps and increments and checks every result
`timescale 1ns/1ns
module long_jump_and_increment_exec_tb;
	import lj_inc_pkg::*;
	logic i_core_clk = 0, i_reset = 1, i_instr_valid = 0;
	logic [15:0] i_instr_word = '0;
	logic [3:0] i_bank_select_register = '0;
	logic o_reg_rd_en, o_reg_wr_en, o_pc_load, o_busy;
	logic [11:0] o_reg_addr;
	logic [7:0] i_reg_rd_data, o_reg_wr_data, o_wreg;
	logic [4:0] o_status;
	logic [20:0] o_pc;
	logic [1:0] o_phase, rd2 = '0;
	logic [21:0] exp_q[$];
	int n_fail = 0, n_tests = 0, cyc = 0;
	long_jump_and_increment_exec u_dut (.i_core_clk, .i_reset, .i_instr_word, .i_instr_valid,
		.i_bank_select_register, .o_reg_rd_en, .o_reg_addr, .i_reg_rd_data, .o_reg_wr_en,
		.o_reg_wr_data, .o_wreg, .o_status, .o_pc, .o_pc_load, .o_phase, .o_busy);
	reg_file_model u_mem (.i_core_clk, .i_rd_en(o_reg_rd_en), .i_addr(o_reg_addr),
		.i_wr_en(o_reg_wr_en), .i_wr_data(o_reg_wr_data), .o_rd_data(i_reg_rd_data));
	task chk(input logic [21:0] seen, input logic [21:0] want);
		n_tests++;
		if (seen !== want) begin
			n_fail++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task wrap_up();
		chk(22'(exp_q.size()), 22'h0);
		if (n_fail == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task pop(input logic [21:0] s);
		if (exp_q.size() == 0) chk(s, ~s);
		else chk(s, exp_q.pop_front());
	endtask
	// a word goes out in the Q1 slot; later cycles carry noise that must be ignored
	task issue(input logic [15:0] w, input logic [3:0] bank);
		do @(negedge i_core_clk); while (o_phase !== PHASE_Q4);
		@(posedge i_core_clk);
		i_instr_word <= w;
		i_instr_valid <= 1'b1;
		i_bank_select_register <= bank;
		@(posedge i_core_clk);
		i_instr_valid <= 1'($urandom);
		i_instr_word <= 16'($urandom);
		i_bank_select_register <= 4'($urandom);
	endtask
	task incr(input logic d, a, input logic [7:0] f, v, input logic [3:0] bank);
		logic [11:0] adr;
		logic [7:0] r;
		adr = {a ? bank : (f < ACCESS_SPLIT_DEFAULT ? ACCESS_LOW_BANK_DEFAULT
			: ACCESS_HIGH_BANK_DEFAULT), f};
		r = v + 8'h01;
		exp_q.push_back({8'h00, d, r, r[7], r == 8'h80, r == 8'h00, v[3:0] == 4'hF, v == 8'hFF});
		issue({INCR_PREFIX, d, a, f}, bank);
		u_mem.mem[adr] = v;
	endtask
	task jump(input logic [19:0] k, input logic ok);
		if (ok) exp_q.push_back({1'b1, k, 1'b0});
		issue({JUMP_FIRST_PREFIX, k[7:0]}, 4'h0);
		repeat (2) @(posedge i_core_clk);
		i_instr_word <= {ok ? JUMP_SECOND_PREFIX : 4'h7, k[19:8]};
		@(posedge i_core_clk);
		i_instr_word <= 16'($urandom);
	endtask
	always @(posedge i_core_clk) rd2 <= {rd2[0], o_reg_rd_en};
	always @(negedge i_core_clk) begin
		if (rd2[1]) pop({8'h00, o_reg_wr_en, o_reg_wr_en ? o_reg_wr_data : o_wreg, o_status});
		if (o_pc_load) pop({1'b1, o_pc});
	end
	initial forever #50 i_core_clk = ~i_core_clk;
	always @(posedge i_core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			wrap_up();
		end
	end
	initial begin
		void'($urandom(10870));
		repeat (8) @(posedge i_core_clk);
		i_reset <= 1'b0;
		incr(1, 0, 8'h10, 8'hFF, 4'h3);
		incr(0, 1, 8'h90, 8'h7F, 4'h5);
		jump(20'h34512, 1);
		jump(20'hABCDE, 0);
		for (int i = 0; i < 32; i++) begin
			if (i % 4 == 3) jump(20'($urandom), 1);
			else incr(1'($urandom), 1'($urandom), 8'($urandom), 8'($urandom), 4'($urandom));
		end
		@(posedge i_core_clk);
		i_instr_valid <= 1'b0;
		repeat (12) @(posedge i_core_clk);
		wrap_up();
	end
endmodule // long_jump_and_increment_exec_tb
bind long_jump_and_increment_exec lj_inc_monitor u_mon (.i_core_clk, .i_reset, .i_instr_word,
	.i_instr_valid, .i_bank_select_register, .o_reg_rd_en, .o_reg_addr, .i_reg_rd_data,
	.o_reg_wr_en, .o_reg_wr_data, .o_wreg, .o_status, .o_pc, .o_pc_load, .o_phase, .o_busy);
